// file: src/trr_bank.sv
// Trace RAM address and trigger routing register bank.
// Assumes a single-cycle register strobe port and trigger lines synchronous to CLK.
`timescale 1ns/1ps
`default_nettype none
// How it works
// R1: End address: 4-bit high, 16-bit low, ones above
// R2: Start address: 4-bit high plus 16-bit low
// R3: Current address readable and writable by host
// R4: Advance select upper byte enables output lines
// R5: Advance select lower byte ORs input lines
// R6: Resets clear advance and open selects
// R7: Open select upper byte enables output lines
// R8: Open select lower byte ORs input lines
// R9: Advance input slope picks acting edge
// R10: Output slope bits pick driven edge
// R11: Open input and busy slopes pick edge
// R12: Resets clear lowest four slope bits
// R13: Polarity bit drives fault indicator
// R14: Absent flags zero; device acknowledges absent modules
// R15: Six flags mark modules joining trace
// R16: Wrap restarts trace from start address
// R17: No wrap: halt and clear run bit
// R18: Run bit enables; kept when wrapping
// R19: Busy route byte toggles lines on release
// R20: Busy trigger enable gates busy events
// R21: Any write to advance slot advances
// R22: Status: bit0 settling, bit6 double wide
// R23: Reserved slots ignore writes, read ones
// R24: Advance steps address and applies state
// R25: End found by comparing current with end
module trr_bank
   import trr_pkg::*;
(
   input  wire logic        CLK,
   input  wire logic        RST_B,
   input  wire logic        SOFT_RST,
   input  wire logic        REG_STB,
   input  wire logic        REG_WR,
   input  wire logic [5:0]  REG_ADDR,
   input  wire logic [15:0] REG_WDATA,
   output logic      [15:0] REG_RDATA,
   output logic             REG_ACK,
   input  wire logic [7:0]  TTL_IN,
   output logic      [7:0]  TTL_OUT,
   output logic      [7:0]  TTL_OE,
   input  wire logic        BOARD_BUSY,
   input  wire logic        DOUBLE_WIDE,
   input  wire logic        MOD_CYC,
   input  wire logic [2:0]  MOD_IDX,
   output logic             MOD_SELF_ACK,
   output logic      [5:0]  MODULE_ABSENT,
   output logic      [19:0] TRACE_ADDR,
   output logic             TRACE_APPLY,
   output logic      [5:0]  TRACE_MODULES,
   output logic             RELAY_OPEN,
   output logic             FAULT_INDICATOR_DRIVE
);

   typedef struct packed {
      logic [19:0] start_a;
      logic [19:0] end_a;
      logic [19:0] cur_a;
      logic [15:0] adv_route;
      logic [15:0] open_route;
      logic [15:0] busy_route;
      logic [4:0]  slope;
      logic        fault;
      logic [5:0]  absent;
      logic [5:0]  part;
      logic [1:0]  spare;
      logic        loop_en;
      logic        run;
      logic [15:0] rdata;
      logic        ack;
      logic [7:0]  ttl_out;
      logic [7:0]  ttl_oe;
      logic        apply;
      logic        open_p;
      logic        self_ack;
   } trr_bank_s;

   trr_bank_s  st_r;
   trr_bank_s  st_nxt;
   trr_trig_if tif ();

   logic       wr;
   logic       rd;
   logic       soft_adv;
   logic       adv_evt;
   logic       busy_evt;
   logic [7:0] settle_output_line_mask;
   logic [7:0] act_lvl;
   logic [7:0] idle_lvl;

   // Feed the edge detector from the current settings
   assign tif.ttl_in    = TTL_IN;
   assign tif.adv_mask  = st_r.adv_route[7:0];
   assign tif.open_mask = st_r.open_route[7:0];
   assign tif.adv_rise  = st_r.slope[POL_ADV_IN];
   assign tif.open_rise = st_r.slope[POL_OPEN_IN];
   assign tif.busy      = BOARD_BUSY;
   assign tif.busy_rise = st_r.slope[POL_BUSY];

   trr_edge_det u_det (
      .CLK   (CLK),
      .RST_B (RST_B),
      .tb    (tif.det)
   );

   // Decoded strobes and merged events
   assign wr       = REG_STB & REG_WR;
   assign rd       = REG_STB & ~REG_WR;
   // R21 write of any value advances
   assign soft_adv = wr && (REG_ADDR == OFF_ADV_STATUS);
   assign adv_evt  = tif.adv_hit | soft_adv;
   // R20 busy events only when enabled
   assign busy_evt = tif.busy_hit & st_r.busy_route[0];
   assign settle_output_line_mask = st_r.busy_route[15:8];

   // Output line levels; advance wins a shared line, then open, then busy
   always_comb
   begin
      act_lvl  = '0;
      idle_lvl = '0;
      for (int i = 0; i < TRIG_W; i++)
      begin
         // R10 output edge polarity
         if (st_r.adv_route[8 + i])
         begin
            act_lvl[i]  = st_r.slope[POL_ADV_OUT];
            idle_lvl[i] = ~st_r.slope[POL_ADV_OUT];
         end
         else if (st_r.open_route[8 + i])
         begin
            act_lvl[i]  = st_r.slope[POL_OPEN_OUT];
            idle_lvl[i] = ~st_r.slope[POL_OPEN_OUT];
         end
         else
         begin
            // Busy release drives a rising active edge by default
            act_lvl[i]  = 1'b1;
            idle_lvl[i] = 1'b0;
         end
      end
   end

   // Next state: host writes first, trace stepping and resets after
   always_comb
   begin
      st_nxt          = st_r;
      st_nxt.ack      = REG_STB;
      st_nxt.apply    = 1'b0;
      st_nxt.self_ack = 1'b0;

      // Host writes
      if (wr)
      begin
         case (REG_ADDR)
            // R2 start address halves
            OFF_START_HI:   st_nxt.start_a[19:16] = REG_WDATA[3:0];
            OFF_START_LO:   st_nxt.start_a[15:0]  = REG_WDATA;
            // R1 end address, upper bits dropped
            OFF_END_HI:     st_nxt.end_a[19:16]   = REG_WDATA[3:0];
            OFF_END_LO:     st_nxt.end_a[15:0]    = REG_WDATA;
            // R3 host sets current address
            OFF_CUR_HI:     st_nxt.cur_a[19:16]   = REG_WDATA[3:0];
            OFF_CUR_LO:     st_nxt.cur_a[15:0]    = REG_WDATA;
            // R4 R5 advance routing
            OFF_ADV_ROUTE:  st_nxt.adv_route      = REG_WDATA;
            // R7 R8 open routing
            OFF_OPEN_ROUTE: st_nxt.open_route     = REG_WDATA;
            OFF_EDGE_POL:
            begin
               st_nxt.slope = REG_WDATA[4:0];
               // R13 fault indicator bit
               st_nxt.fault = REG_WDATA[POL_FAULT];
            end
            OFF_SEQ_CTL:
            begin
               // R14 absent module flags
               st_nxt.absent  = REG_WDATA[15:10];
               // R15 trace participation flags
               st_nxt.part    = REG_WDATA[9:4];
               st_nxt.spare   = REG_WDATA[3:2];
               st_nxt.loop_en = REG_WDATA[SEQ_LOOP];
               st_nxt.run     = REG_WDATA[SEQ_RUN];
            end
            // R19 busy routing byte and spares
            OFF_BUSY_ROUTE: st_nxt.busy_route     = REG_WDATA;
            // R23 reserved slots ignore writes
            default:        st_nxt.busy_route     = st_r.busy_route;
         endcase
      end

      // R24 step on advance while running
      if (adv_evt && st_r.run)
      begin
         st_nxt.apply = 1'b1;
         // R25 end found by address compare
         if (st_r.cur_a == st_r.end_a)
         begin
            // R16 wrap to start of region
            if (st_r.loop_en)
               st_nxt.cur_a = st_r.start_a;
            else
               // R17 halt and clear run
               st_nxt.run = 1'b0;
            // R18 run kept while wrapping
         end
         else
            st_nxt.cur_a = st_r.cur_a + 20'h00001;
      end

      // Trigger outputs pulse to the active level for one cycle
      st_nxt.ttl_oe  = st_r.adv_route[15:8] | st_r.open_route[15:8] | settle_output_line_mask;
      st_nxt.ttl_out = idle_lvl;
      for (int i = 0; i < TRIG_W; i++)
      begin
         // R4 advance toggles enabled lines
         if (adv_evt && st_r.adv_route[8 + i])
            st_nxt.ttl_out[i] = act_lvl[i];
         // R7 open toggles enabled lines
         else if (tif.open_hit && st_r.open_route[8 + i])
            st_nxt.ttl_out[i] = act_lvl[i];
         // R19 busy release toggles lines
         else if (busy_evt && settle_output_line_mask[i])
            st_nxt.ttl_out[i] = act_lvl[i];
      end
      st_nxt.open_p = tif.open_hit;

      // R14 self acknowledge absent module cycles
      if (MOD_CYC && (MOD_IDX < 3'h6))
         st_nxt.self_ack = st_r.absent[MOD_IDX];

      // Read data, registered with the acknowledge
      if (rd)
      begin
         case (REG_ADDR)
            OFF_START_HI:   st_nxt.rdata = hi_word(st_r.start_a);
            OFF_START_LO:   st_nxt.rdata = st_r.start_a[15:0];
            // R1 high word reads ones above
            OFF_END_HI:     st_nxt.rdata = hi_word(st_r.end_a);
            OFF_END_LO:     st_nxt.rdata = st_r.end_a[15:0];
            // R3 current address readback
            OFF_CUR_HI:     st_nxt.rdata = hi_word(st_r.cur_a);
            OFF_CUR_LO:     st_nxt.rdata = st_r.cur_a[15:0];
            OFF_SEQ_CTL:    st_nxt.rdata = {st_r.absent, st_r.part, st_r.spare,
                                            st_r.loop_en, st_r.run};
            OFF_BUSY_ROUTE: st_nxt.rdata = st_r.busy_route;
            // R22 settle and width status
            OFF_ADV_STATUS: st_nxt.rdata = {STAT_FILL, DOUBLE_WIDE, 5'h00, BOARD_BUSY};
            // R23 reserved and write-only read ones
            default:        st_nxt.rdata = RSVD_READ;
         endcase
      end

      // R6 R12 R19 R20 soft reset clears selections
      if (SOFT_RST)
      begin
         st_nxt.adv_route  = ROUTE_RST;
         st_nxt.open_route = ROUTE_RST;
         st_nxt.busy_route = ROUTE_RST;
         st_nxt.slope[3:0] = 4'h0;
      end
   end

   // State register; hard reset clears everything, absent flags included
   always_ff @(posedge CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         st_r         <= '0;
         st_r.start_a <= ADDR_RST;
         st_r.end_a   <= ADDR_RST;
         st_r.cur_a   <= ADDR_RST;
      end
      else
         st_r <= st_nxt;
   end

   // Outputs straight from the state register
   assign REG_RDATA             = st_r.rdata;
   assign REG_ACK               = st_r.ack;
   assign TTL_OUT               = st_r.ttl_out;
   assign TTL_OE                = st_r.ttl_oe;
   assign MOD_SELF_ACK          = st_r.self_ack;
   assign MODULE_ABSENT         = st_r.absent;
   assign TRACE_ADDR            = st_r.cur_a;
   assign TRACE_APPLY           = st_r.apply;
   assign TRACE_MODULES         = st_r.part;
   assign RELAY_OPEN            = st_r.open_p;
   assign FAULT_INDICATOR_DRIVE = st_r.fault;

   // Checks kept beside the logic
   a_soft_route_clr: assert property (@(posedge CLK) disable iff (!RST_B) // R6
      SOFT_RST |=> (st_r.adv_route == 16'h0000) && (st_r.open_route == 16'h0000))
      else $error("soft reset left routing set");

   a_soft_slope_clr: assert property (@(posedge CLK) disable iff (!RST_B) // R12
      SOFT_RST |=> (st_r.slope[3:0] == 4'h0) && !st_r.busy_route[0])
      else $error("soft reset left slope or busy enable set");

   a_wrap_to_start: assert property (@(posedge CLK) disable iff (!RST_B) // R16
      (adv_evt && st_r.run && st_r.loop_en && st_r.cur_a == st_r.end_a && (!wr || soft_adv))
      |=> (TRACE_ADDR == $past(st_r.start_a)) && st_r.run)
      else $error("wrap did not restart at start");

   a_halt_clear_run: assert property (@(posedge CLK) disable iff (!RST_B) // R17
      (adv_evt && st_r.run && !st_r.loop_en && st_r.cur_a == st_r.end_a && (!wr || soft_adv))
      |=> !st_r.run && $stable(TRACE_ADDR) ##1 !TRACE_APPLY)
      else $error("trace did not halt at end");

   a_step_next: assert property (@(posedge CLK) disable iff (!RST_B) // R24
      (adv_evt && st_r.run && st_r.cur_a != st_r.end_a && (!wr || soft_adv))
      |=> TRACE_APPLY && (TRACE_ADDR == $past(st_r.cur_a) + 20'h00001))
      else $error("advance did not step address");

   a_soft_advance: assert property (@(posedge CLK) disable iff (!RST_B) // R21
      (soft_adv && st_r.run) |=> TRACE_APPLY)
      else $error("write to advance slot ignored");

   a_rsvd_ones: assert property (@(posedge CLK) disable iff (!RST_B) // R23
      (rd && REG_ADDR < OFF_START_HI) |=> REG_ACK && (REG_RDATA == 16'hFFFF))
      else $error("reserved slot did not read ones");

   a_end_hi_fill: assert property (@(posedge CLK) disable iff (!RST_B) // R1
      (rd && REG_ADDR == OFF_END_HI) |=> (REG_RDATA[15:4] == 12'hFFF)
      && (REG_RDATA[3:0] == $past(st_r.end_a[19:16])))
      else $error("end high word wrong");

   a_absent_ack: assert property (@(posedge CLK) disable iff (!RST_B) // R14
      (MOD_CYC && MOD_IDX < 3'h6 && st_r.absent[MOD_IDX]) |=> MOD_SELF_ACK)
      else $error("absent module cycle not acknowledged");

   a_fault_drive: assert property (@(posedge CLK) disable iff (!RST_B) // R13
      (wr && REG_ADDR == OFF_EDGE_POL) |=> FAULT_INDICATOR_DRIVE == $past(REG_WDATA[8]))
      else $error("fault indicator not following write");

endmodule : trr_bank
`default_nettype wire

// file: shared/trr_pkg.sv
// Constants, register map and helpers for the trace RAM and trigger routing bank.
// Assumes a 16-bit register port with byte offsets as printed and one 100 MHz clock.
`default_nettype none
package trr_pkg;

   // Register byte offsets on the A16 register port
   localparam logic [5:0] OFF_START_HI   = 6'h28;
   localparam logic [5:0] OFF_START_LO   = 6'h2A;
   localparam logic [5:0] OFF_END_HI     = 6'h2C;
   localparam logic [5:0] OFF_END_LO     = 6'h2E;
   localparam logic [5:0] OFF_CUR_HI     = 6'h30;
   localparam logic [5:0] OFF_CUR_LO     = 6'h32;
   localparam logic [5:0] OFF_ADV_ROUTE  = 6'h34;
   localparam logic [5:0] OFF_OPEN_ROUTE = 6'h36;
   localparam logic [5:0] OFF_EDGE_POL   = 6'h38;
   localparam logic [5:0] OFF_SEQ_CTL    = 6'h3A;
   localparam logic [5:0] OFF_BUSY_ROUTE = 6'h3C;
   localparam logic [5:0] OFF_ADV_STATUS = 6'h3E;

   // Widths
   localparam int ADDR_W = 20;
   localparam int TRIG_W = 8;
   localparam int MOD_N  = 6;

   // Field positions of the polarity register
   localparam int POL_ADV_OUT  = 0;
   localparam int POL_ADV_IN   = 1;
   localparam int POL_OPEN_OUT = 2;
   localparam int POL_OPEN_IN  = 3;
   localparam int POL_BUSY     = 4;
   localparam int POL_FAULT    = 8;

   // Field positions of the sequence control register
   localparam int SEQ_RUN      = 0;
   localparam int SEQ_LOOP     = 1;
   localparam int SEQ_PART_LSB = 4;
   localparam int SEQ_ABS_LSB  = 10;

   // Field positions of the status word
   localparam int STAT_BUSY    = 0;
   localparam int STAT_WIDE    = 6;

   // Reset and fill values
   localparam logic [15:0] RSVD_READ  = 16'hFFFF;
   localparam logic [11:0] HI_FILL    = 12'hFFF;
   localparam logic [8:0]  STAT_FILL  = 9'h1FF;
   localparam logic [15:0] ROUTE_RST  = 16'h0000;
   localparam logic [19:0] ADDR_RST   = 20'h00000;

   // Chosen edge of one sampled level
   function automatic logic edge_hit(input logic prev, input logic cur, input logic rising);
      edge_hit = rising ? (cur & ~prev) : (prev & ~cur);
   endfunction : edge_hit

   // High half of a 20-bit address, upper bits read as ones
   function automatic logic [15:0] hi_word(input logic [19:0] a);
      hi_word = {HI_FILL, a[19:16]};
   endfunction : hi_word

endpackage : trr_pkg
`default_nettype wire

// file: shared/trr_trig_if.sv
// Carrier between the register bank and its trigger edge detector.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface trr_trig_if;
   logic [7:0] ttl_in;
   logic [7:0] adv_mask;
   logic [7:0] open_mask;
   logic       adv_rise;
   logic       open_rise;
   logic       busy;
   logic       busy_rise;
   logic       adv_hit;
   logic       open_hit;
   logic       busy_hit;
   modport bank (output ttl_in, adv_mask, open_mask, adv_rise, open_rise, busy, busy_rise,
                 input adv_hit, open_hit, busy_hit);
   modport det  (input ttl_in, adv_mask, open_mask, adv_rise, open_rise, busy, busy_rise,
                 output adv_hit, open_hit, busy_hit);
endinterface : trr_trig_if
`default_nettype wire

// file: src/trr_edge_det.sv
// Edge detector for routed trigger inputs and the board busy line.
// Assumes inputs already synchronous to CLK; hits are one-cycle pulses.
`timescale 1ns/1ps
`default_nettype none
module trr_edge_det
   import trr_pkg::*;
(
   input  wire logic   CLK,
   input  wire logic   RST_B,
   trr_trig_if.det     tb
);

   typedef struct packed {
      logic adv_prev;
      logic open_prev;
      logic busy_prev;
      logic adv_hit;
      logic open_hit;
      logic busy_hit;
   } trr_det_s;

   trr_det_s st_r;
   trr_det_s st_nxt;
   logic     adv_lvl;
   logic     open_lvl;

   // Enabled lines merged before edge detection
   always_comb
   begin
      // R5 enabled lines ORed
      adv_lvl         = |(tb.ttl_in & tb.adv_mask);
      // R8 enabled lines ORed
      open_lvl        = |(tb.ttl_in & tb.open_mask);
      st_nxt.adv_prev  = adv_lvl;
      st_nxt.open_prev = open_lvl;
      st_nxt.busy_prev = tb.busy;
      // R9 advance input slope
      st_nxt.adv_hit   = edge_hit(st_r.adv_prev, adv_lvl, tb.adv_rise);
      // R11 open and busy slope
      st_nxt.open_hit  = edge_hit(st_r.open_prev, open_lvl, tb.open_rise);
      st_nxt.busy_hit  = edge_hit(st_r.busy_prev, tb.busy, tb.busy_rise);
   end

   // State register
   always_ff @(posedge CLK or negedge RST_B)
   begin
      if (!RST_B)
         st_r <= '0;
      else
         st_r <= st_nxt;
   end

   assign tb.adv_hit  = st_r.adv_hit;
   assign tb.open_hit = st_r.open_hit;
   assign tb.busy_hit = st_r.busy_hit;

   // R5 a rising merged input gives one hit
   a_adv_rise_hit: assert property (@(posedge CLK) disable iff (!RST_B) // R5
      (tb.adv_rise && !st_r.adv_prev && |(tb.ttl_in & tb.adv_mask)) |=> st_r.adv_hit)
      else $error("advance input edge missed");

endmodule : trr_edge_det
`default_nettype wire

// file: verif/trr_ttl_bus.sv
// Trigger bus model: eight pulled-up lines shared with other instruments.
// Assumes the bank drives a line only while its enable for that line is high.
`timescale 1ns/1ps
`default_nettype none
module trr_ttl_bus
(
   input  wire logic [7:0] ttl_out,
   input  wire logic [7:0] ttl_oe,
   input  wire logic [7:0] ext_low,
   output logic      [7:0] ttl_in
);
   // Released lines rest high on the pull-up, never on a stale value
   always_comb
   begin
      for (int i = 0; i < 8; i++)
         ttl_in[i] = ttl_oe[i] ? ttl_out[i] : ~ext_low[i];
   end
endmodule : trr_ttl_bus
`default_nettype wire

// file: verif/trace_ram_trigger_routing_tb_top.sv
// Self-checking bench for the trace address and trigger routing bank.
// Assumes the strobe port of the bank and a pulled-up trigger bus model.
`timescale 1ns/1ps
`default_nettype none
module trace_ram_trigger_routing_tb_top;
   import trr_pkg::*;
   typedef struct {logic wr; logic [5:0] addr; logic [15:0] data;} trr_row_s;
   logic        clk, rst_b, soft_rst, stb, wr, busy, wide, mod_cyc;
   logic [5:0]  addr;
   logic [15:0] wdata, rdata, rd;
   logic [7:0]  ttl_in, ttl_out, ttl_oe, ext_low, out_seen;
   logic [2:0]  mod_idx;
   logic        ack, self_ack, apply, relay_open, fault, ap_seen;
   logic [5:0]  absent, modules;
   logic [19:0] taddr;
   int          miscompares, checked;
   // Plain accesses: reads carry the expected word in data
   trr_row_s    rows [15] = '{
      '{1'b0, OFF_END_HI, 16'hFFF0}, '{1'b1, OFF_END_HI, 16'hABC5},
      '{1'b0, OFF_END_HI, 16'hFFF5}, '{1'b1, OFF_END_LO, 16'h1234},
      '{1'b0, OFF_END_LO, 16'h1234}, '{1'b1, OFF_START_HI, 16'h0002},
      '{1'b0, OFF_START_HI, 16'hFFF2}, '{1'b1, OFF_CUR_LO, 16'hBEEF},
      '{1'b0, OFF_CUR_LO, 16'hBEEF}, '{1'b0, OFF_ADV_ROUTE, 16'hFFFF},
      '{1'b0, OFF_EDGE_POL, 16'hFFFF}, '{1'b1, 6'h00, 16'h1234},
      '{1'b0, 6'h00, 16'hFFFF}, '{1'b1, OFF_BUSY_ROUTE, 16'h00FE},
      '{1'b0, OFF_BUSY_ROUTE, 16'h00FE}};

   trr_bank uut (.CLK(clk), .RST_B(rst_b), .SOFT_RST(soft_rst), .REG_STB(stb),
      .REG_WR(wr), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_RDATA(rdata),
      .REG_ACK(ack), .TTL_IN(ttl_in), .TTL_OUT(ttl_out), .TTL_OE(ttl_oe),
      .BOARD_BUSY(busy), .DOUBLE_WIDE(wide), .MOD_CYC(mod_cyc), .MOD_IDX(mod_idx),
      .MOD_SELF_ACK(self_ack), .MODULE_ABSENT(absent), .TRACE_ADDR(taddr),
      .TRACE_APPLY(apply), .TRACE_MODULES(modules), .RELAY_OPEN(relay_open),
      .FAULT_INDICATOR_DRIVE(fault));

   trr_ttl_bus bus (.ttl_out(ttl_out), .ttl_oe(ttl_oe), .ext_low(ext_low), .ttl_in(ttl_in));

   // 100 MHz clock
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic chk(input logic [19:0] seen, input logic [19:0] exp);
      checked++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic test_done;
      $display("Checks %0d, mismatches %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : test_done

   // One access; answer and trace outputs captured in the answer cycle
   task automatic acc(input logic w, input logic [5:0] a, input logic [15:0] d);
      @(negedge clk);
      stb = 1'b1;
      wr = w;
      addr = a;
      wdata = d;
      @(negedge clk);
      stb = 1'b0;
      rd = rdata;
      ap_seen = apply;
      out_seen = ttl_out;
   endtask : acc

   // Bounded six-cycle window watching one event output, or the open pulse and line 1 together
   task automatic wait_hit(input int sel, output logic hit);
      hit = 1'b0;
      for (int n = 0; n < 6; n++)
      begin
         @(negedge clk);
         hit = hit | (sel == 0 ? apply : sel == 1 ? relay_open : sel == 2 ? ttl_out[7]
                      : relay_open & ttl_out[1]);
      end
   endtask : wait_hit

   task automatic mod_pulse(input logic [2:0] idx);
      @(negedge clk);
      mod_cyc = 1'b1;
      mod_idx = idx;
      @(negedge clk);
      mod_cyc = 1'b0;
   endtask : mod_pulse

   // Hang guard
   initial
   begin
      #1000000;
      miscompares++;
      test_done();
   end

   initial
   begin
      logic hit;
      {rst_b, soft_rst, stb, wr, busy, wide, mod_cyc} = '0;
      addr = 6'h00;
      wdata = 16'h0000;
      ext_low = 8'h00;
      mod_idx = 3'h0;
      repeat (2) @(negedge clk);
      rst_b = 1'b1;
      chk(ttl_oe, 8'h00);
      chk(absent, 6'h00);
      foreach (rows[i])
      begin
         acc(rows[i].wr, rows[i].addr, rows[i].data);
         if (!rows[i].wr)
            chk(rd, rows[i].data);
      end
      chk(taddr, 20'h0BEEF);
      // Region 0x20010..0x20012, current one below the end
      acc(1'b1, OFF_START_LO, 16'h0010);
      acc(1'b1, OFF_END_HI, 16'h0002);
      acc(1'b1, OFF_END_LO, 16'h0012);
      acc(1'b1, OFF_CUR_HI, 16'h0002);
      acc(1'b1, OFF_CUR_LO, 16'h0011);
      acc(1'b1, OFF_SEQ_CTL, 16'h0013);
      acc(1'b1, OFF_ADV_ROUTE, 16'h0100);
      acc(1'b1, OFF_EDGE_POL, 16'h0001);
      @(negedge clk);
      chk(ttl_oe, 8'h01);
      acc(1'b1, OFF_ADV_STATUS, 16'h1234);
      chk(ap_seen, 1'b1);
      chk(taddr, 20'h20012);
      chk(out_seen, 8'h01);
      acc(1'b1, OFF_ADV_STATUS, 16'h0000);
      chk(taddr, 20'h20010);
      acc(1'b0, OFF_SEQ_CTL, 16'h0000);
      chk(rd, 16'h0013);
      chk(modules, 6'h01);
      // Wrap off: step to the end, then halt
      acc(1'b1, OFF_SEQ_CTL, 16'h0011);
      repeat (2) acc(1'b1, OFF_ADV_STATUS, 16'h0000);
      chk(taddr, 20'h20012);
      acc(1'b1, OFF_ADV_STATUS, 16'h0000);
      chk(ap_seen, 1'b1);
      chk(taddr, 20'h20012);
      acc(1'b0, OFF_SEQ_CTL, 16'h0000);
      chk(rd, 16'h0010);
      acc(1'b1, OFF_ADV_STATUS, 16'h0000);
      chk(ap_seen, 1'b0);
      chk(out_seen, 8'h01);
      // Routed inputs: advance on line 2 falling, open on line 3 rising
      acc(1'b1, OFF_SEQ_CTL, 16'h0013);
      acc(1'b1, OFF_ADV_ROUTE, 16'h0004);
      acc(1'b1, OFF_OPEN_ROUTE, 16'h0208);
      acc(1'b1, OFF_EDGE_POL, 16'h000C);
      @(negedge clk);
      chk(ttl_oe, 8'h02);
      ext_low[2] = 1'b1;
      wait_hit(0, hit);
      chk(hit, 1'b1);
      ext_low[2] = 1'b0;
      wait_hit(0, hit);
      chk(hit, 1'b0);
      ext_low[3] = 1'b1;
      wait_hit(1, hit);
      chk(hit, 1'b0);
      ext_low[3] = 1'b0;
      wait_hit(3, hit);
      chk(hit, 1'b1);
      // Busy release drives line 7 only while enabled
      acc(1'b1, OFF_BUSY_ROUTE, 16'h8001);
      busy = 1'b1;
      wide = 1'b1;
      acc(1'b0, OFF_ADV_STATUS, 16'h0000);
      chk(rd, 16'hFFC1);
      busy = 1'b0;
      wait_hit(2, hit);
      chk(hit, 1'b1);
      acc(1'b1, OFF_BUSY_ROUTE, 16'h8000);
      busy = 1'b1;
      repeat (3) @(negedge clk);
      busy = 1'b0;
      wait_hit(2, hit);
      chk(hit, 1'b0);
      // Rising busy slope acts on assertion
      acc(1'b1, OFF_EDGE_POL, 16'h001C);
      acc(1'b1, OFF_BUSY_ROUTE, 16'h8001);
      busy = 1'b1;
      wait_hit(2, hit);
      chk(hit, 1'b1);
      // Soft reset clears routing and low slopes, keeps the indicator
      acc(1'b1, OFF_EDGE_POL, 16'h010F);
      @(negedge clk);
      chk(fault, 1'b1);
      // Rising advance slope on line 2
      ext_low[2] = 1'b1;
      @(negedge clk);
      ext_low[2] = 1'b0;
      wait_hit(0, hit);
      chk(hit, 1'b1);
      soft_rst = 1'b1;
      @(negedge clk);
      soft_rst = 1'b0;
      @(negedge clk);
      chk(ttl_oe, 8'h00);
      chk(fault, 1'b1);
      acc(1'b0, OFF_BUSY_ROUTE, 16'h0000);
      chk(rd, 16'h0000);
      acc(1'b1, OFF_OPEN_ROUTE, 16'h0200);
      @(negedge clk);
      chk(ttl_out[1], 1'b1);
      // Absent module cycles answered by the bank itself
      mod_pulse(3'h2);
      chk(self_ack, 1'b0);
      acc(1'b1, OFF_SEQ_CTL, 16'h1000);
      chk(absent, 6'h04);
      mod_pulse(3'h2);
      chk(self_ack, 1'b1);
      // Hard reset with the run bit clear clears routing, flags and indicator
      rst_b = 1'b0;
      @(negedge clk);
      rst_b = 1'b1;
      chk(ttl_oe, 8'h00);
      chk(absent, 6'h00);
      chk(fault, 1'b0);
      test_done();
   end
endmodule : trace_ram_trigger_routing_tb_top
`default_nettype wire
